// File: can_far_node.sv
// Far-side CAN node model: wired-AND bus level seen by the block
`timescale 1ns/1ps
`default_nettype none
module can_far_node (
  input  wire logic tx_active_in,
  input  wire logic tx_level_in,
  input  wire logic dominant_in,
  output logic      bus_level_out
);
  // Recessive is 1; the bus pull-up keeps it recessive when nobody drives
  // far dominant wins
  assign bus_level_out = (tx_active_in ? tx_level_in : 1'b1) & ~dominant_in;
endmodule // can_far_node
`default_nettype wire

// File: can_obj_pkg.sv
// Constants for the CAN message object status and identifier tag block
package can_obj_pkg;
  // Register addresses in the special function register space
  localparam logic [7:0] ADDR_STATUS   = 8'hb2;
  localparam logic [7:0] ADDR_CONTROL  = 8'hb3;
  localparam logic [7:0] ADDR_PAGE     = 8'hb1;
  localparam logic [7:0] ADDR_ID_TAG_1 = 8'hbc;
  localparam logic [7:0] ADDR_ID_TAG_2 = 8'hbd;
  localparam logic [7:0] ADDR_ID_TAG_3 = 8'hbe;
  localparam logic [7:0] ADDR_ID_TAG_4 = 8'hbf;
  // Status flag bit positions
  localparam int BIT_RX_OK    = 5;
  localparam int BIT_BIT_ERR  = 4;
  localparam int BIT_STUFF    = 3;
  localparam int BIT_CRC      = 2;
  localparam int BIT_FORM     = 1;
  localparam int BIT_ACK      = 0;
  localparam int STATUS_FLAGS = 6;
  // Control and page register fields
  localparam int CTL_IDE_BIT  = 4;
  localparam int PAGE_OBJ_LSB = 4;
  // Tag register layout fields
  localparam int TAG_RTR_BIT  = 2;
  localparam int TAG_RB1_BIT  = 1;
  localparam int TAG_RB0_BIT  = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // CAN bit counts
  localparam int STUFF_LIMIT  = 5;
  localparam int CRC_WIDTH    = 15;
  localparam logic [14:0] CRC_POLY = 15'h4599;
endpackage : can_obj_pkg

// File: can_obj_status.sv
// Message object status flags, error checks and identifier tag registers
`timescale 1ns/1ps
`default_nettype none
module can_obj_status #(
  parameter int N_OBJ = 4,
  parameter int OBJ_W = 2
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  // Special function register port
  input  wire logic [7:0]       sfr_addr_in,
  input  wire logic [7:0]       sfr_wdata_in,
  input  wire logic             sfr_wr_in,
  input  wire logic             sfr_rd_in,
  output logic      [7:0]       sfr_rdata_out,
  // Protocol engine events, same clock
  input  wire logic             bit_tick_in,
  input  wire logic             tx_active_in,
  input  wire logic             tx_level_in,
  input  wire logic             rx_level_in,
  input  wire logic             in_arbitration_in,
  input  wire logic             in_ack_slot_in,
  input  wire logic             in_crc_field_in,
  input  wire logic             crc_check_in,
  input  wire logic             stuff_check_in,
  input  wire logic             fixed_form_in,
  input  wire logic             frame_start_in,
  input  wire logic             rx_done_in,
  input  wire logic [N_OBJ-1:0] rx_hit_in,
  output logic      [N_OBJ-1:0] rx_grant_out,
  output logic      [N_OBJ-1:0] obj_ide_out,
  output logic      [N_OBJ-1:0] obj_rb1_out,
  output logic                  irq_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Object page and per-object storage
  logic [OBJ_W-1:0] page_q;
  logic [7:0]       status_q [N_OBJ];
  logic [7:0]       ctrl_q   [N_OBJ];
  logic [7:0]       tag_q    [N_OBJ][4];
  logic [7:0]       cur_ctrl;
  logic             cur_ide;
  logic             wr_status, wr_ctrl, wr_page, wr_tag;
  logic [1:0]       tag_sel;

  // Register write decode
  assign wr_status = sfr_wr_in && (sfr_addr_in == can_obj_pkg::ADDR_STATUS);
  assign wr_ctrl   = sfr_wr_in && (sfr_addr_in == can_obj_pkg::ADDR_CONTROL);
  assign wr_page   = sfr_wr_in && (sfr_addr_in == can_obj_pkg::ADDR_PAGE);
  assign wr_tag    = sfr_wr_in && (sfr_addr_in[7:2] == can_obj_pkg::ADDR_ID_TAG_1[7:2]);
  assign tag_sel   = sfr_addr_in[1:0];
  assign cur_ctrl  = ctrl_q[page_q];
  assign cur_ide   = cur_ctrl[can_obj_pkg::CTL_IDE_BIT];

  // Page select picks which object the registers show
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      page_q <= '0;
    end else if (wr_page) begin
      page_q <= sfr_wdata_in[can_obj_pkg::PAGE_OBJ_LSB +: OBJ_W];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit-level error detection
  logic [2:0]  same_cnt_q;
  logic        last_level_q;
  logic [14:0] crc_q;
  logic        crc_fb;
  logic        bit_err, stuff_err, crc_err, form_err, ack_err;
  logic        ack_seen_q;
  logic        ack_slot_q;

  // recessive lost in arbitration or ack slot is legal
  assign bit_err = bit_tick_in && tx_active_in && (tx_level_in != rx_level_in)
                   && !(in_arbitration_in && tx_level_in && !rx_level_in)
                   && !in_ack_slot_in;
  // sixth equal bit flags a stuff violation
  assign stuff_err = bit_tick_in && stuff_check_in && (rx_level_in == last_level_q)
                     && (same_cnt_q == 3'(can_obj_pkg::STUFF_LIMIT));
  // CRC compare at end of CRC field
  assign crc_err = crc_check_in && (crc_q != '0);
  assign form_err = bit_tick_in && fixed_form_in && !rx_level_in;
  // ack slot ended with no dominant seen
  assign ack_err = ack_slot_q && !in_ack_slot_in && !ack_seen_q;
  assign crc_fb  = rx_level_in ^ crc_q[can_obj_pkg::CRC_WIDTH-1];

  // Run length, CRC shift and ack watch; CRC runs through the CRC field so
  // a good frame leaves a zero remainder
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      same_cnt_q   <= '0;
      last_level_q <= 1'b1;
      crc_q        <= '0;
      ack_seen_q   <= 1'b0;
      ack_slot_q   <= 1'b0;
    end else begin
      ack_slot_q <= in_ack_slot_in;
      if (frame_start_in) begin
        crc_q      <= '0;
        same_cnt_q <= '0;
        ack_seen_q <= 1'b0;
      end else if (bit_tick_in) begin
        last_level_q <= rx_level_in;
        same_cnt_q   <= (rx_level_in == last_level_q) ? same_cnt_q + 3'h1 : 3'h1;
        if (in_ack_slot_in && !rx_level_in) begin
          ack_seen_q <= 1'b1;
        end
        if (stuff_check_in || in_crc_field_in) begin
          crc_q <= {crc_q[13:0], 1'b0} ^ (crc_fb ? can_obj_pkg::CRC_POLY : 15'h0000);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive grant and per-object status flags
  logic [N_OBJ-1:0] grant;
  logic [N_OBJ-1:0] irq_vec;

  can_rx_select #(.N_OBJ(N_OBJ)) u_select (
    .hit_in    (rx_hit_in),
    .grant_out (grant)
  );
  assign rx_grant_out = rx_done_in ? grant : '0;

  // Error flags land in the selected object; set wins over clear
  genvar g;
  generate
    for (g = 0; g < N_OBJ; g++) begin : g_obj
      logic [7:0] set_v;
      logic [7:0] clr_v;
      logic       sel;
      assign sel   = (page_q == OBJ_W'(g));
      // receive complete on lowest granted object
      assign set_v = {2'b00, rx_grant_out[g],
                      sel & bit_err, sel & stuff_err, sel & crc_err,
                      sel & form_err, sel & ack_err};
      // Software writes zero to clear a flag
      assign clr_v = (wr_status && sel) ? ~sfr_wdata_in : 8'h00;
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          status_q[g] <= can_obj_pkg::STATUS_RESET;
        end else begin
          status_q[g] <= (status_q[g] & ~clr_v) | set_v;
        end
      end
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl_q[g] <= '0;
        end else if (wr_ctrl && sel) begin
          ctrl_q[g] <= sfr_wdata_in;
        end
      end
      always_ff @(posedge mclk_in) begin
        if (wr_tag && sel) begin
          tag_q[g][tag_sel] <= sfr_wdata_in;
        end
      end
      assign obj_ide_out[g] = ctrl_q[g][can_obj_pkg::CTL_IDE_BIT];
      // reserved bit 1 value per object
      assign obj_rb1_out[g] = tag_q[g][3][can_obj_pkg::TAG_RB1_BIT];
      assign irq_vec[g] = |status_q[g][can_obj_pkg::STATUS_FLAGS-1:0];
    end
  endgenerate

  assign irq_out = |irq_vec;

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [7:0] tag_raw;
  logic [7:0] tag_view;
  assign tag_raw = tag_q[page_q][tag_sel];
  // storage holds the written byte; layout is fixed by
  // the identifier extension bit, standard reads drop nothing so the
  // reserved bits return whatever was stored
  // reserved bits read undefined stored content
  assign tag_view = tag_raw;

  // Address decode for reads
  always_comb begin
    if (!sfr_rd_in) begin
      sfr_rdata_out = 8'h00;
    end else if (sfr_addr_in == can_obj_pkg::ADDR_STATUS) begin
      sfr_rdata_out = status_q[page_q];
    end else if (sfr_addr_in == can_obj_pkg::ADDR_CONTROL) begin
      sfr_rdata_out = cur_ctrl;
    end else if (sfr_addr_in == can_obj_pkg::ADDR_PAGE) begin
      sfr_rdata_out = 8'({page_q, 4'h0});
    end else if (sfr_addr_in[7:2] == can_obj_pkg::ADDR_ID_TAG_1[7:2]) begin
      sfr_rdata_out = tag_view;
    end else begin
      sfr_rdata_out = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Bit error only while transmitting
  a_bit_err_tx: assert property (@(posedge mclk_in) disable iff (rst_in)
    bit_err |-> tx_active_in) else $error("bit error outside transmit");
  a_ack_slot_skip: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_ack_slot_in |-> !bit_err) else $error("bit error in ack slot");
  a_rx_ok_set: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_grant_out[0] |=> status_q[0][can_obj_pkg::BIT_RX_OK])
    else $error("receive complete not set");
  a_grant_lowest: assert property (@(posedge mclk_in) disable iff (rst_in)
    (rx_done_in && rx_hit_in[0]) |-> (rx_grant_out == N_OBJ'(1)))
    else $error("lowest object not granted");
  a_flag_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
    (status_q[0][can_obj_pkg::BIT_ACK] && !(wr_status && page_q == '0))
    |=> status_q[0][can_obj_pkg::BIT_ACK]) else $error("flag lost");
  a_irq_follows: assert property (@(posedge mclk_in) disable iff (rst_in)
    (|status_q[0][5:0]) |-> irq_out) else $error("interrupt missing");
  a_ack_err_cause: assert property (@(posedge mclk_in) disable iff (rst_in)
    ack_err |-> $past(in_ack_slot_in)) else $error("ack error off slot");
  a_form_err_set: assert property (@(posedge mclk_in) disable iff (rst_in)
    (form_err && page_q == '0) |=> status_q[0][can_obj_pkg::BIT_FORM])
    else $error("form error not set");
  a_stuff_err_set: assert property (@(posedge mclk_in) disable iff (rst_in)
    (stuff_err && page_q == '0) |=> status_q[0][can_obj_pkg::BIT_STUFF])
    else $error("stuff error not set");
endmodule // can_obj_status
`default_nettype wire

// File: can_obj_status_tb.sv
// Self-checking bench for the message object status and tag block
`timescale 1ns/1ps
`default_nettype none
module can_obj_status_tb;
  logic       mclk_in, rst_in, sfr_wr_in, sfr_rd_in, bit_tick_in, frame_start_in;
  logic       rx_done_in, irq_out, bus_level, crc_check_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [6:0] ev;  // Tx active, tx level, far dominant, arbitration, ack slot, stuffed, form
  logic [3:0] rx_hit_in, rx_grant_out, obj_ide_out, obj_rb1_out;
  int         num_errors = 0, total_checks = 0, cycles = 0;

  initial mclk_in = 1'b0;
  always #10 mclk_in = ~mclk_in;

  can_far_node far_u (.tx_active_in(ev[6]), .tx_level_in(ev[5]), .dominant_in(ev[4]),
    .bus_level_out(bus_level));
  can_obj_status #(.N_OBJ(4), .OBJ_W(2)) dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .bit_tick_in(bit_tick_in),
    .tx_active_in(ev[6]), .tx_level_in(ev[5]), .rx_level_in(bus_level),
    .in_arbitration_in(ev[3]), .in_ack_slot_in(ev[2]), .in_crc_field_in(1'b0),
    .crc_check_in(crc_check_in), .stuff_check_in(ev[1]), .fixed_form_in(ev[0]),
    .frame_start_in(frame_start_in), .rx_done_in(rx_done_in), .rx_hit_in(rx_hit_in),
    .rx_grant_out(rx_grant_out), .obj_ide_out(obj_ide_out), .obj_rb1_out(obj_rb1_out),
    .irq_out(irq_out));

  ////////////////////////////////////////////////////////////////////////////////
  // Byte compare; narrower results are zero-extended by the caller
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(posedge mclk_in);
    #1;
    sfr_wr_in = 1'b0;
  endtask

  // Read data is combinational, so it is sampled mid-cycle while the strobe stands
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk_in);
    #1;
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    #5;
    chk(sfr_rdata_out & m, e);
    @(posedge mclk_in);
    #1;
    sfr_rd_in = 1'b0;
  endtask

  // One tick per CAN bit, the levels held from one tick to the next
  task automatic bit_go(input logic [6:0] f, input int n);
    repeat (n) begin
      @(posedge mclk_in);
      #1;
      ev = f;
      bit_tick_in = 1'b1;
      @(posedge mclk_in);
      #1;
      bit_tick_in = 1'b0;
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, well above the roughly 180 cycles the sequence needs
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    {sfr_wr_in, sfr_rd_in, bit_tick_in, frame_start_in, rx_done_in, crc_check_in} = 6'h00;
    {sfr_addr_in, sfr_wdata_in, ev, rx_hit_in} = 27'h0;
    repeat (10) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    rd(8'hb2, 8'hff, 8'h00);
    rd(8'hb0, 8'hff, 8'h00);
    // Odd objects extended, even standard with reserved bit 1 zero and reserved bit 0 set
    for (int o = 0; o < 4; o++) begin
      wr(8'hb1, 8'(o * 16));
      wr(8'hb3, o[0] ? 8'h10 : 8'h00);
      wr(8'hbc, 8'(8'h81 + o));
      wr(8'hbd, o[0] ? 8'h5a : 8'ha0);
      wr(8'hbe, o[0] ? 8'hc3 : 8'h00);
      wr(8'hbf, o[0] ? 8'h7a : 8'h05);
    end
    for (int o = 0; o < 4; o++) begin
      wr(8'hb1, 8'(o * 16));
      rd(8'hbc, 8'hff, 8'(8'h81 + o));
      rd(8'hbd, o[0] ? 8'hff : 8'he0, o[0] ? 8'h5a : 8'ha0);
      rd(8'hbe, o[0] ? 8'hff : 8'h00, o[0] ? 8'hc3 : 8'h00);
      rd(8'hbf, o[0] ? 8'hff : 8'h05, o[0] ? 8'h7a : 8'h05);
    end
    chk({4'h0, obj_ide_out}, 8'h0a);
    chk({4'h0, obj_rb1_out}, 8'h0a);
    // Two objects hit by one frame
    @(posedge mclk_in);
    #1;
    rx_hit_in = 4'b1100;
    rx_done_in = 1'b1;
    #5;
    chk({4'h0, rx_grant_out}, 8'h04);
    @(posedge mclk_in);
    #1;
    rx_done_in = 1'b0;
    rx_hit_in = 4'h0;
    wr(8'hb1, 8'h30);
    rd(8'hb2, 8'h3f, 8'h00);
    wr(8'hb1, 8'h20);
    rd(8'hb2, 8'h3f, 8'h20);
    chk({7'h0, irq_out}, 8'h01);
    wr(8'hb2, 8'hff);
    rd(8'hb2, 8'h3f, 8'h20);
    wr(8'hb2, 8'h00);
    rd(8'hb2, 8'h3f, 8'h00);
    chk({7'h0, irq_out}, 8'h00);
    // Bus errors land in the paged object
    wr(8'hb1, 8'h00);
    bit_go(7'b1111000, 1);
    bit_go(7'b0110000, 1);
    bit_go(7'b1110100, 1);
    bit_go(7'b0000000, 1);
    rd(8'hb2, 8'h3f, 8'h00);
    bit_go(7'b1110000, 1);
    rd(8'hb2, 8'h3f, 8'h10);
    bit_go(7'b0000000, 1);
    wr(8'hb2, 8'h00);
    bit_go(7'b0010010, 5);
    rd(8'hb2, 8'h3f, 8'h00);
    bit_go(7'b0010010, 1);
    rd(8'hb2, 8'h3f, 8'h08);
    wr(8'hb2, 8'h00);
    bit_go(7'b0010001, 1);
    rd(8'hb2, 8'h3f, 8'h02);
    wr(8'hb2, 8'h00);
    // New frame: clears the CRC and the earlier ack sighting
    @(posedge mclk_in);
    #1;
    frame_start_in = 1'b1;
    @(posedge mclk_in);
    #1;
    frame_start_in = 1'b0;
    // One recessive stuffed bit leaves a nonzero remainder
    bit_go(7'b0000010, 1);
    @(posedge mclk_in);
    #1;
    crc_check_in = 1'b1;
    @(posedge mclk_in);
    #1;
    crc_check_in = 1'b0;
    rd(8'hb2, 8'h3f, 8'h04);
    wr(8'hb2, 8'h00);
    @(posedge mclk_in);
    #1;
    frame_start_in = 1'b1;
    @(posedge mclk_in);
    #1;
    frame_start_in = 1'b0;
    bit_go(7'b0000100, 1);
    bit_go(7'b0000000, 1);
    rd(8'hb2, 8'h3f, 8'h01);
    chk({7'h0, irq_out}, 8'h01);
    close_out();
  end
endmodule // can_obj_status_tb
`default_nettype wire

// File: can_rx_select.sv
// Lowest-index selection of message objects hit by one received frame
`timescale 1ns/1ps
`default_nettype none
module can_rx_select #(
  parameter int N_OBJ = 4
) (
  input  wire logic [N_OBJ-1:0] hit_in,
  output logic      [N_OBJ-1:0] grant_out
);
  // One-hot of lowest set bit: x & -x
  // lowest index first
  assign grant_out = hit_in & (~hit_in + N_OBJ'(1));
endmodule // can_rx_select
`default_nettype wire
